// File: src/ddrrc_params.svh
/*
  Timing, pin-field and encoding constants of the refresh-aware DDR
  command sequencer.
  Assumes a 50 MHz mclk and a DDR clock made by dividing mclk by two.
*/
`ifndef DDRRC_PARAMS_SVH
`define DDRRC_PARAMS_SVH

// ****************************************
// Clocking
// ****************************************
`define DDRRC_TCK_NS 20
`define DDRRC_MCLK_PER_CK 2
`define DDRRC_CK_NS (`DDRRC_TCK_NS * `DDRRC_MCLK_PER_CK)

// ****************************************
// Pin fields
// ****************************************
`define DDRRC_ALL_BANK_BIT 10
`define DDRRC_BL 2
`define DDRRC_CL 2
`define DDRRC_FAST_AP 0

// ****************************************
// Device times in ns and CK, counts in mclk
// ****************************************
`define DDRRC_T_RCD_NS 15
`define DDRRC_T_RAS_NS 40
`define DDRRC_T_RP_NS 15
`define DDRRC_T_WR_NS 15
`define DDRRC_T_RFC_NS 70
`define DDRRC_T_XSNR_NS 75
`define DDRRC_T_REFI_NS 15625
`define DDRRC_XSRD_CK 200
`define DDRRC_UP(ns) (((ns) + `DDRRC_TCK_NS - 1) / `DDRRC_TCK_NS)
`define DDRRC_C_RCD `DDRRC_UP(`DDRRC_T_RCD_NS)
`define DDRRC_C_RAS `DDRRC_UP(`DDRRC_T_RAS_NS)
`define DDRRC_C_RP `DDRRC_UP(`DDRRC_T_RP_NS)
`define DDRRC_C_WR `DDRRC_UP(`DDRRC_T_WR_NS)
`define DDRRC_C_RFC `DDRRC_UP(`DDRRC_T_RFC_NS)
`define DDRRC_C_XSNR `DDRRC_UP(`DDRRC_T_XSNR_NS)
`define DDRRC_C_XSRD (`DDRRC_XSRD_CK * `DDRRC_MCLK_PER_CK)
`define DDRRC_C_REFI (`DDRRC_T_REFI_NS / `DDRRC_TCK_NS)
// Auto-closing read guard, rounded up like every least time
`define DDRRC_T_RAPX_NS (`DDRRC_T_RAS_NS - `DDRRC_BL * `DDRRC_CK_NS / 2)
`define DDRRC_C_RAPX `DDRRC_UP(`DDRRC_T_RAPX_NS)
`define DDRRC_C_RAP ((`DDRRC_FAST_AP || `DDRRC_C_RAPX < `DDRRC_C_RCD) ? \
  `DDRRC_C_RCD : `DDRRC_C_RAPX)
`define DDRRC_C_RW (((`DDRRC_BL / 2) + `DDRRC_CL + 2) * \
  `DDRRC_MCLK_PER_CK + `DDRRC_C_WR + `DDRRC_C_RP)
`define DDRRC_C_RDCAP 7
`define DDRRC_C_REF_SLACK 64

`endif

// File: src/ddrrc_pkg.sv
/*
  Types of the DDR command sequencer: command codes and FSM states.
  Assumes the constants header is included by every user.
*/
package ddrrc_pkg;

  typedef logic [1:0] ddrrc_bank_t;
  typedef logic [11:0] ddrrc_addr_t;

  // RAS, CAS, WE code of each command
  typedef enum logic [2:0] {
    DDRRC_NOP = 3'h7,
    DDRRC_ACT = 3'h3,
    DDRRC_RD  = 3'h5,
    DDRRC_WR  = 3'h4,
    DDRRC_PRE = 3'h2,
    DDRRC_REF = 3'h1
  } ddrrc_cmd_t;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_OPEN = 8'h02,
    S_PRE  = 8'h04,
    S_ACT  = 8'h08,
    S_RW   = 8'h10,
    S_REF  = 8'h20,
    S_SR   = 8'h40,
    S_XS   = 8'h80
  } ddrrc_state_t;

endpackage

// File: src/ddrrc_timer.sv
/*
  Loadable down counter used for every command spacing guard.
  Assumes load values fit ten bits; done is high at zero.
*/
`timescale 1ns/1ns
module ddrrc_timer (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic load,
  input wire logic [9:0] val,
  output logic done
);
  import ddrrc_pkg::*;

  logic [9:0] cnt_q;
  logic [9:0] cnt_d;

  // A fresh load wins over the running count
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = val;
    end else if (cnt_q != 10'h000) begin
      cnt_d = cnt_q - 10'h001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 10'h000;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == 10'h000);
endmodule

// File: src/ddrrc_ctrl.sv
/*
  DDR SDRAM command sequencer: activation, auto-closing or open-row
  reads and writes of two beats, periodic auto refresh and self refresh.
  Assumes the DDR clock pins are driven from here at mclk / 2 and the
  user keeps req fields stable while req_valid is high.
*/
`timescale 1ns/1ns
`include "ddrrc_params.svh"
module ddrrc_ctrl (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_autopre,
  input wire ddrrc_pkg::ddrrc_bank_t req_bank,
  input wire ddrrc_pkg::ddrrc_addr_t req_row,
  input wire logic [7:0] req_col,
  input wire logic [31:0] req_wdata,
  input wire logic [3:0] req_wmask,
  input wire logic sr_req,
  output logic req_ready,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic sr_active,
  output logic ddr_ck,
  output logic ddr_ck_n,
  output logic ddr_cke,
  output logic ddr_cs_n,
  output logic ddr_ras_n,
  output logic ddr_cas_n,
  output logic ddr_we_n,
  output ddrrc_pkg::ddrrc_bank_t ddr_ba,
  output ddrrc_pkg::ddrrc_addr_t ddr_addr,
  output logic [1:0] ddr_dm,
  output logic [15:0] ddr_dq_out,
  output logic ddr_dq_oe,
  input wire logic [15:0] ddr_dq_in,
  output logic [1:0] ddr_dqs_out,
  output logic ddr_dqs_oe
);
  import ddrrc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  ddrrc_state_t st_q, st_d;
  ddrrc_cmd_t cmd_q, cmd_d;
  ddrrc_bank_t ba_q, ba_d;
  ddrrc_addr_t addr_q, addr_d;
  logic ck_q, ck_d, ckn_q, ckn_d, cke_q, cke_d, iss_q, iss_d;
  logic rdy_q, rdy_d, refdue_q, refdue_d, pend_q, pend_d;
  logic [3:0] open_q, open_d;
  logic p_wr_q, p_wr_d, p_ap_q, p_ap_d;
  ddrrc_bank_t p_ba_q, p_ba_d;
  ddrrc_addr_t p_row_q, p_row_d;
  logic [7:0] p_col_q, p_col_d;
  logic [31:0] p_wd_q, p_wd_d;
  logic [3:0] p_wm_q, p_wm_d;
  logic [2:0] wph_q, wph_d;
  logic [3:0] rdc_q, rdc_d;
  logic [15:0] dq_q, dq_d, rdd_q, rdd_d;
  logic [1:0] dm_q, dm_d, dqs_q, dqs_d;
  logic dqoe_q, dqoe_d, dqsoe_q, dqsoe_d, rdv_q, rdv_d;
  logic [15:0] dqs1_q, dqs2_q;
  logic take, sra_q;
  logic ld_w, ld_ras, ld_refi, ld_rdg;
  logic [9:0] wval;
  logic w_done, ras_done, refi_done, rdg_done;

  // ****************************************
  // Spacing timers
  // ****************************************
  ddrrc_timer u_wait (.mclk(mclk), .arst_n(arst_n), .ce(ce), .load(ld_w),
    .val(wval), .done(w_done));
  ddrrc_timer u_ras (.mclk(mclk), .arst_n(arst_n), .ce(ce), .load(ld_ras),
    .val(10'(`DDRRC_C_RAS)), .done(ras_done));
  ddrrc_timer u_refi (.mclk(mclk), .arst_n(arst_n), .ce(ce),
    .load(ld_refi), .val(10'(`DDRRC_C_REFI)), .done(refi_done));
  ddrrc_timer u_rdg (.mclk(mclk), .arst_n(arst_n), .ce(ce), .load(ld_rdg),
    .val(10'(`DDRRC_C_XSRD)), .done(rdg_done));

  assign take = req_valid & rdy_q;

  // Sequencer; commands change as CK falls so they are stable at rise
  always_comb begin
    st_d = st_q; cmd_d = cmd_q; ba_d = ba_q; addr_d = addr_q;
    ck_d = ~ck_q; ckn_d = ck_q; cke_d = cke_q; iss_d = 1'b0;
    open_d = open_q; pend_d = pend_q;
    p_wr_d = p_wr_q; p_ap_d = p_ap_q; p_ba_d = p_ba_q; p_row_d = p_row_q;
    p_col_d = p_col_q; p_wd_d = p_wd_q; p_wm_d = p_wm_q;
    ld_w = 1'b0; ld_ras = 1'b0; ld_refi = 1'b0; ld_rdg = 1'b0;
    wval = 10'h000;
    refdue_d = refdue_q | refi_done;
    if (take) begin
      pend_d = 1'b1; p_wr_d = req_write; p_ap_d = req_autopre;
      p_ba_d = req_bank; p_row_d = req_row; p_col_d = req_col;
      p_wd_d = req_wdata; p_wm_d = req_wmask;
    end
    if (ck_q) begin
      cmd_d = DDRRC_NOP;
      unique case (st_q)
        S_IDLE: begin
          if (take) begin
            st_d = S_OPEN;
          end else if ((sr_req | refdue_q) && open_q != 4'h0) begin
            cmd_d = DDRRC_PRE;
            addr_d = 12'h000;
            addr_d[`DDRRC_ALL_BANK_BIT] = 1'b1;
            open_d = 4'h0; iss_d = 1'b1; ld_w = 1'b1;
            wval = 10'(`DDRRC_C_RP); st_d = S_PRE;
          end else if (sr_req) begin
            cmd_d = DDRRC_REF; cke_d = 1'b0; iss_d = 1'b1;
            refdue_d = 1'b0; st_d = S_SR;
          end else if (refdue_q) begin
            cmd_d = DDRRC_REF; iss_d = 1'b1; refdue_d = 1'b0;
            ld_refi = 1'b1; ld_w = 1'b1;
            wval = 10'(`DDRRC_C_RFC); st_d = S_REF;
          end
        end
        S_OPEN: begin
          if (!open_q[p_ba_q]) begin
            cmd_d = DDRRC_ACT; ba_d = p_ba_q; addr_d = p_row_q;
            open_d[p_ba_q] = 1'b1; iss_d = 1'b1; ld_ras = 1'b1;
            ld_w = 1'b1; st_d = S_ACT;
            wval = (p_ap_q && !p_wr_q) ? 10'(`DDRRC_C_RAP) :
              10'(`DDRRC_C_RCD);
          end else if (ras_done) begin
            cmd_d = DDRRC_PRE; ba_d = p_ba_q; addr_d = 12'h000;
            open_d[p_ba_q] = 1'b0; iss_d = 1'b1; ld_w = 1'b1;
            wval = 10'(`DDRRC_C_RP); st_d = S_PRE;
          end
        end
        S_PRE: begin
          if (w_done) begin
            st_d = pend_q ? S_OPEN : S_IDLE;
          end
        end
        S_ACT: begin
          if (w_done && (p_wr_q || rdg_done)) begin
            cmd_d = p_wr_q ? DDRRC_WR : DDRRC_RD; ba_d = p_ba_q;
            addr_d = {4'h0, p_col_q};
            addr_d[`DDRRC_ALL_BANK_BIT] = p_ap_q;
            if (p_ap_q) begin
              open_d[p_ba_q] = 1'b0;
            end
            iss_d = 1'b1; ld_w = 1'b1; wval = 10'(`DDRRC_C_RW);
            st_d = S_RW;
          end
        end
        S_RW: begin
          if (w_done) begin
            pend_d = 1'b0; st_d = S_IDLE;
          end
        end
        S_REF: begin
          if (w_done) begin
            st_d = S_IDLE;
          end
        end
        S_SR: begin
          if (!sr_req) begin
            cke_d = 1'b1; ld_w = 1'b1; ld_rdg = 1'b1; ld_refi = 1'b1;
            wval = 10'(`DDRRC_C_XSNR); st_d = S_XS;
          end
        end
        S_XS: begin
          if (w_done) begin
            st_d = S_IDLE;
          end
        end
      endcase
    end
    // Offer a slot only on the cycle before a command slot
    rdy_d = ck_d & (st_d == S_IDLE) & ~pend_d & ~sr_req & ~refdue_d;
  end

  // Write strobe and read capture; strobe rises on a CK rising edge and falls on the next CK falling edge
  always_comb begin
    wph_d = wph_q; rdc_d = rdc_q; rdd_d = rdd_q; rdv_d = 1'b0;
    if (iss_q && cmd_q == DDRRC_WR) begin
      wph_d = 3'h1;
    end else if (wph_q != 3'h0) begin
      wph_d = (wph_q == 3'h6) ? 3'h0 : wph_q + 3'h1;
    end
    dqsoe_d = (wph_d >= 3'h2) && (wph_d <= 3'h5);
    dqs_d = {2{wph_d == 3'h3}};
    dqoe_d = (wph_d == 3'h3) || (wph_d == 3'h4);
    dq_d = (wph_d == 3'h4) ? p_wd_q[31:16] : p_wd_q[15:0];
    dm_d = (wph_d == 3'h4) ? p_wm_q[3:2] : p_wm_q[1:0];
    if (iss_q && cmd_q == DDRRC_RD) begin
      rdc_d = 4'h1;
    end else if (rdc_q != 4'h0) begin
      rdc_d = (rdc_q == 4'(`DDRRC_C_RDCAP + 1)) ? 4'h0 : rdc_q + 4'h1;
    end
    if (rdc_q >= 4'(`DDRRC_C_RDCAP)) begin
      rdd_d = dqs2_q; rdv_d = 1'b1;
    end
  end

  // Only registering; the CE low freezes every flop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_IDLE; cmd_q <= DDRRC_NOP; ba_q <= 2'h0; addr_q <= 12'h000;
      ck_q <= 1'b0; ckn_q <= 1'b1; cke_q <= 1'b1; iss_q <= 1'b0;
      rdy_q <= 1'b0; refdue_q <= 1'b0; pend_q <= 1'b0; open_q <= 4'h0;
      p_wr_q <= 1'b0; p_ap_q <= 1'b0; p_ba_q <= 2'h0; p_row_q <= 12'h000;
      p_col_q <= 8'h00; p_wd_q <= 32'h0000_0000; p_wm_q <= 4'h0;
      wph_q <= 3'h0; rdc_q <= 4'h0; dq_q <= 16'h0000; rdd_q <= 16'h0000;
      dm_q <= 2'h0; dqs_q <= 2'h0; dqoe_q <= 1'b0; dqsoe_q <= 1'b0;
      rdv_q <= 1'b0; dqs1_q <= 16'h0000; dqs2_q <= 16'h0000;
      sra_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d; cmd_q <= cmd_d; ba_q <= ba_d; addr_q <= addr_d;
      ck_q <= ck_d; ckn_q <= ckn_d; cke_q <= cke_d; iss_q <= iss_d;
      rdy_q <= rdy_d; refdue_q <= refdue_d; pend_q <= pend_d;
      open_q <= open_d; p_wr_q <= p_wr_d; p_ap_q <= p_ap_d;
      p_ba_q <= p_ba_d; p_row_q <= p_row_d; p_col_q <= p_col_d;
      p_wd_q <= p_wd_d; p_wm_q <= p_wm_d; wph_q <= wph_d; rdc_q <= rdc_d;
      dq_q <= dq_d; rdd_q <= rdd_d; dm_q <= dm_d; dqs_q <= dqs_d;
      dqoe_q <= dqoe_d; dqsoe_q <= dqsoe_d; rdv_q <= rdv_d;
      dqs1_q <= ddr_dq_in; dqs2_q <= dqs1_q; // Pin synchroniser
      sra_q <= ~cke_d; // Own flop so the flag is glitch free
    end
  end

  assign req_ready = rdy_q;
  assign rd_data = rdd_q;
  assign rd_valid = rdv_q;
  assign sr_active = sra_q;
  assign ddr_ck = ck_q;
  assign ddr_ck_n = ckn_q;
  assign ddr_cke = cke_q;
  assign ddr_cs_n = 1'b0; // Single device, always selected
  assign ddr_ras_n = cmd_q[2];
  assign ddr_cas_n = cmd_q[1];
  assign ddr_we_n = cmd_q[0];
  assign ddr_ba = ba_q;
  assign ddr_addr = addr_q;
  assign ddr_dm = dm_q;
  assign ddr_dq_out = dq_q;
  assign ddr_dq_oe = dqoe_q;
  assign ddr_dqs_out = dqs_q;
  assign ddr_dqs_oe = dqsoe_q;

  // ****************************************
  // Checks: cycle distances since key commands
  // ****************************************
  logic [9:0] s_act_q, s_ref_q, s_xs_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_act_q <= 10'h3FF; s_ref_q <= 10'h001; s_xs_q <= 10'h3FF;
    end else if (ce) begin
      s_act_q <= (iss_q && cmd_q == DDRRC_ACT) ? 10'h001 :
        (s_act_q == 10'h3FF ? s_act_q : s_act_q + 10'h001);
      // Distance in mclk since the last refresh, true distance not offset
      s_ref_q <= (!cke_q || (iss_q && cmd_q == DDRRC_REF)) ? 10'h001 :
        (s_ref_q == 10'h3FF ? s_ref_q : s_ref_q + 10'h001);
      s_xs_q <= !cke_q ? 10'h000 :
        (s_xs_q == 10'h3FF ? s_xs_q : s_xs_q + 10'h001);
    end
  end

  ref_all_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
    iss_q && cmd_q == DDRRC_REF |-> open_q == 4'h0)
    else $error("refresh issued with a bank open");
  ref_gap_a: assert property (@(posedge mclk) disable iff (!arst_n)
    iss_q && cke_q && cmd_q != DDRRC_REF |-> s_ref_q > 10'(`DDRRC_C_RFC))
    else $error("command inside refresh cycle time");
  ref_float_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_q == S_REF || st_q == S_SR) |-> !ddr_dq_oe && !ddr_dqs_oe)
    else $error("data driven during refresh");
  sr_entry_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(cke_q) |-> open_q == 4'h0 && cmd_q == DDRRC_REF)
    else $error("self refresh entered with open bank");
  xs_nonread_a: assert property (@(posedge mclk) disable iff (!arst_n)
    iss_q && cmd_q != DDRRC_RD |-> s_xs_q > 10'(`DDRRC_C_XSNR))
    else $error("command too soon after self refresh exit");
  xs_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    iss_q && cmd_q == DDRRC_RD |-> s_xs_q > 10'(`DDRRC_C_XSRD))
    else $error("read before strobe loop relock");
  rap_guard_a: assert property (@(posedge mclk) disable iff (!arst_n)
    iss_q && cmd_q == DDRRC_RD && addr_q[`DDRRC_ALL_BANK_BIT]
    |-> s_act_q > 10'(`DDRRC_C_RAP))
    else $error("auto-closing read too early");
  pre_ras_a: assert property (@(posedge mclk) disable iff (!arst_n)
    iss_q && cmd_q == DDRRC_PRE |-> s_act_q > 10'(`DDRRC_C_RAS))
    else $error("precharge before row-active time");
  strobe_edge_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(ddr_dqs_out[0]) |-> ddr_ck && ddr_dqs_oe ##1 !ddr_dqs_out[0])
    else $error("write strobe off clock edge");
  refi_bound_a: assert property (@(posedge mclk) disable iff (!arst_n)
    cke_q |-> s_ref_q <= 10'(`DDRRC_C_REFI + `DDRRC_C_REF_SLACK))
    else $error("refresh interval exceeded");

  rd_ap_c: cover property (@(posedge mclk) disable iff (!arst_n)
    iss_q && cmd_q == DDRRC_RD && addr_q[`DDRRC_ALL_BANK_BIT]);
  pre_all_c: cover property (@(posedge mclk) disable iff (!arst_n)
    iss_q && cmd_q == DDRRC_PRE && addr_q[`DDRRC_ALL_BANK_BIT]);
  sr_exit_c: cover property (@(posedge mclk) disable iff (!arst_n)
    $rose(cke_q));
endmodule

// File: testbench/ddrrc_dram_model.sv
/*
  Behavioural DDR device: decodes commands at CK rise, keeps data and
  counts spacing faults of the sequencer in viol, one slot per rule.
  Assumes the sequencer owns CK and holds chip select low.
*/
`timescale 1ns/1ns
`include "ddrrc_params.svh"
module ddrrc_dram_model (
  input wire logic mclk,
  input wire logic ddr_ck,
  input wire logic ddr_cke,
  input wire logic ddr_ras_n,
  input wire logic ddr_cas_n,
  input wire logic ddr_we_n,
  input wire ddrrc_pkg::ddrrc_bank_t ddr_ba,
  input wire ddrrc_pkg::ddrrc_addr_t ddr_addr,
  input wire logic [1:0] ddr_dm,
  input wire logic [15:0] ddr_dq_out,
  input wire logic ddr_dq_oe,
  input wire logic [1:0] ddr_dqs_out,
  input wire logic ddr_dqs_oe,
  output logic [15:0] ddr_dq_in
);
  import ddrrc_pkg::*;
  // ********
  // Device state
  // ********
  localparam longint CK = `DDRRC_CK_NS;
  localparam longint RAP = (`DDRRC_FAST_AP != 0) ? `DDRRC_T_RCD_NS :
    `DDRRC_T_RAS_NS - `DDRRC_BL * CK / 2;
  logic [15:0] mem [logic [21:0]];
  ddrrc_addr_t row [4];
  longint t_act [4];
  longint now;
  longint t_ref = 0;
  longint t_exit = -100000;
  longint t_ck = 0;
  longint t_dqs;
  logic [3:0] open_q = 4'h0;
  logic [2:0] cmd;
  logic [21:0] adr, wadr;
  logic [15:0] b0, b1, w;
  logic in_sr = 1'b0;
  logic seen_ref = 1'b0;
  int viol [14] = '{default: 0};
  int ref_cnt = 0;
  int rd_e = 0;
  int wbeat = 2;

  // Read beats CL clocks on; a released bus toggles, never holds
  always @(posedge ddr_ck or negedge ddr_ck) begin
    if (rd_e == 2 * `DDRRC_CL)
      ddr_dq_in <= #5 b0;
    else if (rd_e == 2 * `DDRRC_CL + 1)
      ddr_dq_in <= #5 b1;
    else
      ddr_dq_in <= #5 ~ddr_dq_in;
    rd_e = (rd_e == 0 || rd_e > 2 * `DDRRC_CL) ? 0 : rd_e + 1;
    if (ddr_ck) begin
      now = longint'($time);
      t_ck = now;
      cmd = {ddr_ras_n, ddr_cas_n, ddr_we_n};
      adr = {ddr_ba, row[ddr_ba], ddr_addr[7:0]};
      if (!ddr_cke && !in_sr) begin
        in_sr = 1'b1;
        if (open_q != 4'h0) viol[5]++;
      end else if (ddr_cke && in_sr) begin
        in_sr = 1'b0;
        t_exit = now;
        t_ref = now;
      end else if (!in_sr && cmd != DDRRC_NOP) begin
        if (now - t_ref < `DDRRC_T_RFC_NS) viol[3]++;
        if (cmd != DDRRC_RD && now - t_exit < `DDRRC_T_XSNR_NS)
          viol[6]++;
        case (cmd)
          DDRRC_ACT: begin
            open_q[ddr_ba] = 1'b1;
            t_act[ddr_ba] = now;
            row[ddr_ba] = ddr_addr;
          end
          DDRRC_RD: begin
            if (now - t_exit < 200 * CK) viol[7]++;
            if (!open_q[ddr_ba] || now - t_act[ddr_ba] < `DDRRC_T_RCD_NS ||
                (ddr_addr[10] && now - t_act[ddr_ba] < RAP))
              viol[8]++;
            b0 = mem.exists(adr) ? mem[adr] : 16'h0000;
            b1 = mem.exists(adr + 22'h1) ? mem[adr + 22'h1] : 16'h0000;
            rd_e = 1;
            if (ddr_addr[10]) open_q[ddr_ba] = 1'b0;
          end
          DDRRC_WR: begin
            wadr = adr;
            wbeat = 0;
            if (ddr_addr[10]) open_q[ddr_ba] = 1'b0;
          end
          DDRRC_PRE:
            for (int b = 0; b < 4; b++)
              if (open_q[b] && (ddr_addr[10] || ddr_ba == b)) begin
                if (now - t_act[b] < `DDRRC_T_RAS_NS) viol[11]++;
                open_q[b] = 1'b0;
              end
          DDRRC_REF: begin
            if (open_q != 4'h0) viol[1]++;
            if (seen_ref && now - t_ref > 2 * `DDRRC_T_REFI_NS)
              viol[13]++;
            seen_ref = 1'b1;
            t_ref = now;
            ref_cnt++;
          end
          default: ;
        endcase
      end
    end
  end

  // Beats taken mid-cycle so none races its own launch edge
  always @(negedge mclk) begin
    if (ddr_dq_oe && wbeat < 2 && !in_sr) begin
      w = mem.exists(wadr + 22'(wbeat)) ? mem[wadr + 22'(wbeat)] : 16'h0;
      if (!ddr_dm[0]) w[7:0] = ddr_dq_out[7:0];
      if (!ddr_dm[1]) w[15:8] = ddr_dq_out[15:8];
      mem[wadr + 22'(wbeat)] = w;
      wbeat++;
    end
  end

  // Every strobe rise must meet a CK rise within a quarter clock
  always @(posedge ddr_dqs_out[0]) begin
    if (ddr_dqs_oe) begin
      t_dqs = longint'($time);
      #(CK / 4);
      if (t_ck < t_dqs - CK / 4) viol[12]++;
    end
  end
endmodule

// File: testbench/tb_top.sv
/*
  Self-checking bench: corner and random accesses, self refresh, refresh.
  Assumes the device model counts spacing faults per rule in viol.
*/
`timescale 1ns/1ns
module tb_top;
  import ddrrc_pkg::*;
  logic mclk, arst_n, ce, req_valid, req_write, req_autopre, sr_req;
  ddrrc_bank_t req_bank, ddr_ba;
  ddrrc_addr_t req_row, ddr_addr;
  logic [7:0] req_col;
  logic [31:0] req_wdata;
  logic [3:0] req_wmask;
  logic req_ready, rd_valid, sr_active, ddr_ck, ddr_ck_n, ddr_cke, ddr_cs_n;
  logic ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_dq_oe, ddr_dqs_oe;
  logic [15:0] rd_data, ddr_dq_out, ddr_dq_in;
  logic [1:0] ddr_dm, ddr_dqs_out;
  logic [15:0] shadow [logic [21:0]];
  int err_count = 0;
  int checks_done = 0;

  ddrrc_ctrl u_ddrrc_ctrl (.mclk, .arst_n, .ce, .req_valid, .req_write,
    .req_autopre, .req_bank, .req_row, .req_col, .req_wdata, .req_wmask,
    .sr_req, .req_ready, .rd_data, .rd_valid, .sr_active, .ddr_ck,
    .ddr_ck_n, .ddr_cke, .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n,
    .ddr_ba, .ddr_addr, .ddr_dm, .ddr_dq_out, .ddr_dq_oe, .ddr_dq_in,
    .ddr_dqs_out, .ddr_dqs_oe);
  ddrrc_dram_model u_ddrrc_dram_model (.mclk, .ddr_ck, .ddr_cke,
    .ddr_ras_n, .ddr_cas_n, .ddr_we_n, .ddr_ba, .ddr_addr, .ddr_dm,
    .ddr_dq_out, .ddr_dq_oe, .ddr_dqs_out, .ddr_dqs_oe, .ddr_dq_in);

  // ********
  // Checking helpers
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Bounded wait; running out is a mismatch and ends the run
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (sig !== lvl && n < lim);
    if (sig !== lvl) begin
      check(sig, lvl);
      end_of_test();
    end
  endtask

  // Masked byte lanes keep the old contents
  function automatic logic [15:0] merge(logic [21:0] a, logic [15:0] d,
                                        logic [1:0] m);
    logic [15:0] o;
    o = shadow.exists(a) ? shadow[a] : 16'h0000;
    return {m[1] ? o[15:8] : d[15:8], m[0] ? o[7:0] : d[7:0]};
  endfunction

  // One request; reads are compared beat by beat against the shadow
  task automatic access(input logic wr, input logic ap, input logic [21:0] a,
                        input logic [31:0] d, input logic [3:0] m);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_autopre <= ap;
    {req_bank, req_row, req_col} <= a;
    req_wdata <= d;
    req_wmask <= m;
    wait_for(req_ready, 1'b1, 3000);
    req_valid <= 1'b0;
    if (wr) begin
      shadow[a] = merge(a, d[15:0], m[1:0]);
      shadow[a + 22'h1] = merge(a + 22'h1, d[31:16], m[3:2]);
    end else begin
      wait_for(rd_valid, 1'b1, 1000);
      check(rd_data, merge(a, 16'h0, 2'h3));
      @(posedge mclk);
      check({rd_valid, rd_data}, {1'b1, merge(a + 22'h1, 16'h0, 2'h3)});
    end
  endtask

  // Enter, stay a random while, leave, then access at once
  task automatic self_refresh(input logic rd_first, input logic [21:0] a);
    @(posedge mclk);
    sr_req <= 1'b1;
    wait_for(sr_active, 1'b1, 3000);
    repeat ($urandom_range(300, 40)) @(posedge mclk);
    check({ddr_cke, ddr_dq_oe, ddr_dqs_oe}, 32'h0);
    sr_req <= 1'b0;
    wait_for(sr_active, 1'b0, 3000);
    if (rd_first) access(1'b0, 1'b1, a, 32'h0, 4'h0);
    access(1'b1, 1'b0, a, $urandom, 4'h0);
    access(1'b0, 1'b0, a, 32'h0, 4'h0);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ********
  // Main sequence
  // ********
  initial begin
    logic [21:0] a;
    logic ck_held;
    arst_n = 1'b0;
    ce = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_autopre = 1'b0;
    {req_bank, req_row, req_col} = 22'h0;
    req_wdata = 32'h0;
    req_wmask = 4'h0;
    sr_req = 1'b0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    void'($urandom(76674));
    // Auto-closing write then read right after activation, every bank
    for (int b = 0; b < 4; b++) begin
      a = {2'(b), 12'h400, 8'hFE};
      access(1'b1, 1'b1, a, $urandom, 4'h6);
      access(1'b0, 1'b1, a, 32'h0, 4'h0);
    end
    // Few rows per bank, so rows clash, stay open and meet refresh
    for (int i = 0; i < 80; i++) begin
      a = {2'($urandom), 12'($urandom_range(3, 0) << 10), 7'($urandom), 1'b0};
      access(1'($urandom), 1'($urandom), a, $urandom, 4'($urandom));
    end
    // Clock enable low freezes the DDR clock; wait out any write burst
    repeat (20) @(posedge mclk);
    ce <= 1'b0;
    repeat (2) @(posedge mclk);
    ck_held = ddr_ck;
    repeat (4) @(posedge mclk);
    check({ddr_ck, ddr_cs_n, ddr_ck_n ^ ddr_ck}, {29'h0, ck_held, 2'b01});
    ce <= 1'b1;
    self_refresh(1'b1, a);
    self_refresh(1'b0, a);
    repeat (2000) @(posedge mclk);
    check(u_ddrrc_dram_model.viol[1], 32'h0);
    check(u_ddrrc_dram_model.viol[3], 32'h0);
    check(u_ddrrc_dram_model.viol[5], 32'h0);
    check(u_ddrrc_dram_model.viol[6], 32'h0);
    check(u_ddrrc_dram_model.viol[7], 32'h0);
    check(u_ddrrc_dram_model.viol[8], 32'h0);
    check(u_ddrrc_dram_model.viol[11], 32'h0);
    check(u_ddrrc_dram_model.viol[12], 32'h0);
    check(u_ddrrc_dram_model.viol[13], 32'h0);
    check(u_ddrrc_dram_model.ref_cnt > 3, 32'h1);
    end_of_test();
  end
endmodule
